/* File: sraa_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sraa_regs.svh"
module sraa_top (
  input wire logic clk,
  input wire logic sys_rst,
  // four-wire pins, sampled by clk
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  // two-wire protocol engine access (byte level, same clock)
  input wire logic tw_addr_valid,
  input wire logic [7:0] tw_addr,
  input wire logic tw_wdata_valid,
  input wire logic [7:0] tw_wdata,
  input wire logic tw_rd_req,
  output logic [7:0] tw_rdata,
  // register file port
  output logic reg_wr,
  output sraa_pkg::sraa_ptr_t reg_addr,
  output sraa_pkg::sraa_byte_t reg_wdata,
  input wire sraa_pkg::sraa_byte_t reg_rdata,
  // alert
  input wire logic [`SRAA_NUM_MEAS-1:0] conv_done,
  input wire logic [`SRAA_NUM_MEAS-1:0] over_upper_limit,
  input wire logic [`SRAA_NUM_MEAS-1:0] under_lower_limit,
  input wire logic alert_polarity_bit,
  input wire logic alert_disable_bit,
  output logic [`SRAA_NUM_MEAS-1:0] int_status,
  output logic alert_o,
  output logic alert_oe,
  output logic four_wire_locked
);
  import sraa_pkg::*;

  sraa_link_if link ();

  // ==========================================================
  // pin front end: the device never drives a clock, it only samples one
  sraa_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .cs_n_pin(cs_n),
    .sclk_pin(sclk),
    .din_pin(din),
    .link(link)
  );

  sraa_alert u_alert (
    .clk(clk),
    .sys_rst(sys_rst),
    .conv_done(conv_done),
    .over_upper_limit(over_upper_limit),
    .under_lower_limit(under_lower_limit),
    .alert_polarity_bit(alert_polarity_bit),
    .alert_disable_bit(alert_disable_bit),
    .int_status(int_status),
    .alert_o(alert_o),
    .alert_oe(alert_oe)
  );

  // ==========================================================
  // interface mode lock
  logic lock_q, lock_d;
  logic [1:0] edge_cnt_q, edge_cnt_d;

  // counting is done on sys clock so no pin edge is ever used as a clock
  always_comb begin
    lock_d = lock_q;
    edge_cnt_d = edge_cnt_q;
    if (!lock_q && link.cs_rise) begin
      edge_cnt_d = edge_cnt_q + 2'h1;
      if (edge_cnt_d == `SRAA_LOCK_EDGES) begin
        lock_d = 1'b1;
      end
    end
  end

  // reset stands in for power cycling; nothing else clears the lock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
      edge_cnt_q <= 2'h0;
    end else begin
      lock_q <= lock_d;
      edge_cnt_q <= edge_cnt_d;
    end
  end

  assign four_wire_locked = lock_q;

  // ==========================================================
  // four-wire shift engine
  sraa_state_t st_q, st_d;
  sraa_ptr_t ptr_q, ptr_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic dout_q, dout_d;
  logic act_q, act_d;
  logic sw_wr, tw_wr;
  logic [7:0] sh_next;
  logic load_tx;

  always_comb begin
    st_d = st_q;
    ptr_d = ptr_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    dout_d = dout_q;
    act_d = act_q;
    sw_wr = 1'b0;
    load_tx = 1'b0;
    sh_next = {sh_q[6:0], link.din};
    if (lock_q && link.cs_fall) begin
      // every select assertion is a fresh transaction
      act_d = 1'b1;
      st_d = SRAA_CMD;
      bit_d = 3'h0;
    end else if (lock_q && link.cs_rise) begin
      act_d = 1'b0;
    end else if (act_q && link.cs_low && link.sclk_rise) begin
      sh_d = sh_next;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        case (st_q)
          SRAA_CMD: begin
            if (sh_next == `SRAA_CMD_WRITE) begin
              st_d = SRAA_ADDR;
            end else if (sh_next == `SRAA_CMD_READ) begin
              st_d = SRAA_RDATA;
              load_tx = 1'b1;
            end else begin
              act_d = 1'b0; // unknown command: ignore rest of frame
            end
          end
          SRAA_ADDR: begin
            ptr_d = sh_next[5:0];
            st_d = SRAA_WDATA;
          end
          SRAA_WDATA: begin
            sw_wr = 1'b1;
            ptr_d = (ptr_q == `SRAA_PTR_LAST) ? `SRAA_PTR_FIRST : ptr_q + 6'h1;
          end
          SRAA_RDATA: begin
            ptr_d = (ptr_q == `SRAA_PTR_LAST) ? `SRAA_PTR_FIRST : ptr_q + 6'h1;
            load_tx = 1'b1;
          end
          default: begin
            st_d = SRAA_CMD;
          end
        endcase
      end
    end else if (act_q && link.cs_low && link.sclk_fall && st_q == SRAA_RDATA) begin
      dout_d = tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
    if (load_tx) begin
      // next byte comes from the pointer after any advance
      tx_d = reg_rdata;
    end
    if (tw_addr_valid && !lock_q) begin
      ptr_d = tw_addr[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= SRAA_CMD;
      ptr_q <= `SRAA_PTR_FIRST;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      dout_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ptr_q <= ptr_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      dout_q <= dout_d;
      act_q <= act_d;
    end
  end

  // ==========================================================
  // register port and two-wire access
  // two-wire write keeps the pointer, so repeated bytes hit one register
  assign tw_wr = tw_wdata_valid & ~lock_q;
  // read data port reflects the pointer just updated for a read load
  assign reg_addr = (load_tx && st_q == SRAA_RDATA) ?
                    ((ptr_q == `SRAA_PTR_LAST) ? `SRAA_PTR_FIRST : ptr_q + 6'h1) : ptr_q;
  assign reg_wr = sw_wr | tw_wr;
  assign reg_wdata = sw_wr ? sh_next : tw_wdata;

  logic [7:0] tw_rd_q, tw_rd_d;
  // two-wire read returns one byte and leaves the pointer alone
  always_comb begin
    tw_rd_d = tw_rd_q;
    if (tw_rd_req && !lock_q) begin
      tw_rd_d = reg_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tw_rd_q <= 8'h00;
    end else begin
      tw_rd_q <= tw_rd_d;
    end
  end

  assign tw_rdata = tw_rd_q;
  // float whenever deselected or not returning data
  assign dout_o = dout_q;
  assign dout_oe = act_q & link.cs_low & (st_q == SRAA_RDATA);
endmodule
`default_nettype wire

/* File: sraa_regs.svh */
`ifndef SRAA_REGS_SVH
`define SRAA_REGS_SVH
// ==========================================================
// four-wire command bytes
`define SRAA_CMD_WRITE 8'h90
`define SRAA_CMD_READ 8'h91
// ==========================================================
// pointer range
`define SRAA_PTR_FIRST 6'h00
`define SRAA_PTR_LAST 6'h3f
// ==========================================================
// alert control field reset values
`define SRAA_POL_RESET 1'h0
`define SRAA_DIS_RESET 1'h0
// ==========================================================
// measurement count: internal temp, external temp, supply, four analog inputs
`define SRAA_NUM_MEAS 7
// ==========================================================
// lock sequence: rising edges of chip select while in two-wire mode
`define SRAA_LOCK_EDGES 2'h3
`endif

/* File: sraa_pkg.sv */
`default_nettype none
package sraa_pkg;
  // four-wire framing states
  typedef enum logic [3:0] {
    SRAA_CMD = 4'h1,
    SRAA_ADDR = 4'h2,
    SRAA_WDATA = 4'h4,
    SRAA_RDATA = 4'h8
  } sraa_state_t;
  typedef logic [5:0] sraa_ptr_t;
  typedef logic [7:0] sraa_byte_t;
endpackage
`default_nettype wire

/* File: sraa_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// synchronised link events passed from the front end to the protocol engine
interface sraa_link_if;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;
  logic din;
  modport src (output cs_fall, cs_rise, cs_low, sclk_rise, sclk_fall, din);
  modport dst (input cs_fall, cs_rise, cs_low, sclk_rise, sclk_fall, din);
endinterface
`default_nettype wire

/* File: sraa_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module sraa_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic din_pin,
  sraa_link_if.src link
);
  logic [2:0] cs_q, cs_d;
  logic [2:0] sclk_q, sclk_d;
  logic [1:0] din_q, din_d;

  // ==========================================================
  // two-stage synchronisers plus one history stage for edges
  always_comb begin
    cs_d = {cs_q[1:0], cs_n_pin};
    sclk_d = {sclk_q[1:0], sclk_pin};
    din_d = {din_q[0], din_pin};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_q <= 3'h7; // idle: deselected
      sclk_q <= 3'h0;
      din_q <= 2'h0;
    end else begin
      cs_q <= cs_d;
      sclk_q <= sclk_d;
      din_q <= din_d;
    end
  end

  // edges only look at the second and third stages, never the first flop
  assign link.cs_fall = cs_q[2] & ~cs_q[1];
  assign link.cs_rise = ~cs_q[2] & cs_q[1];
  assign link.cs_low = ~cs_q[1];
  assign link.sclk_rise = ~sclk_q[2] & sclk_q[1];
  assign link.sclk_fall = sclk_q[2] & ~sclk_q[1];
  assign link.din = din_q[1];
endmodule
`default_nettype wire

/* File: sraa_alert.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sraa_regs.svh"
module sraa_alert (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`SRAA_NUM_MEAS-1:0] conv_done,
  input wire logic [`SRAA_NUM_MEAS-1:0] over_upper_limit,
  input wire logic [`SRAA_NUM_MEAS-1:0] under_lower_limit,
  input wire logic alert_polarity_bit,
  input wire logic alert_disable_bit,
  output logic [`SRAA_NUM_MEAS-1:0] int_status,
  output logic alert_o,
  output logic alert_oe
);
  logic [`SRAA_NUM_MEAS-1:0] viol_q, viol_d;
  logic act_q, act_d;

  // ==========================================================
  // per-measurement violation: updated by each new conversion result
  genvar i;
  generate
    for (i = 0; i < `SRAA_NUM_MEAS; i++) begin : g_meas
      always_comb begin
        viol_d[i] = viol_q[i];
        if (conv_done[i]) begin
          viol_d[i] = over_upper_limit[i] | under_lower_limit[i];
        end
      end
    end
  endgenerate

  // pin level: active when enabled and any source offends
  always_comb begin
    act_d = ~alert_disable_bit & (|viol_d);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      viol_q <= '0;
      act_q <= 1'b0;
    end else begin
      viol_q <= viol_d;
      act_q <= act_d;
    end
  end

  assign int_status = viol_q;
  // open drain: only ever drives low; polarity picks when the pull-down is on
  assign alert_o = 1'b0;
  assign alert_oe = alert_polarity_bit ? ~act_q : act_q;
endmodule
`default_nettype wire

/* File: sraa_spi_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench-side master: 48 ns bit cells, clock parked low
module sraa_spi_master (
  output var logic cs_n,
  output var logic sclk,
  output var logic din,
  input wire logic dout_o,
  input wire logic dout_oe
);
  // idle: deselected, no clock from the device side
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b1;
  end
  // three select pulses
  task automatic lock_seq();
    repeat (3) begin
      #24 cs_n = 1'b0;
      #24 cs_n = 1'b1;
    end
    #48;
  endtask
  // din moves while sclk is low, dout taken on the rise
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #24 sclk = 1'b1;
      rx[i] = dout_oe ? dout_o : 1'bx;
      #24 sclk = 1'b0;
    end
  endtask
  // a frame is bounded by select; idle din flips so stale bits never look valid
  task automatic open_f();
    cs_n = 1'b0;
    #24;
  endtask
  task automatic close_f();
    #24 cs_n = 1'b1;
    din = ~din;
    #48;
  endtask
endmodule
`default_nettype wire

/* File: sraa_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sraa_regs.svh"
module sraa_top_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic tw_wdata_valid,
  input wire logic reg_wr,
  input wire logic [`SRAA_NUM_MEAS-1:0] conv_done,
  input wire logic [`SRAA_NUM_MEAS-1:0] over_upper_limit,
  input wire logic [`SRAA_NUM_MEAS-1:0] under_lower_limit,
  input wire logic alert_polarity_bit,
  input wire logic alert_disable_bit,
  input wire logic [`SRAA_NUM_MEAS-1:0] int_status,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic four_wire_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // pins and mode
  open_drain_a: assert property (alert_o == 1'b0) else $error("alert drives high");
  deselect_float_a: assert property (cs_n [*6] |-> !dout_oe) else $error("dout driven idle");
  drive_locked_a: assert property (dout_oe |-> four_wire_locked) else $error("dout unlocked");
  lock_holds_a: assert property (four_wire_locked |=> four_wire_locked) else $error("lock lost");
  dout_fall_a: assert property (dout_oe && $changed(dout_o) |-> !sclk) else $error("dout moved high");
  tw_write_a: assert property (tw_wdata_valid && !four_wire_locked |-> ##[0:1] reg_wr)
    else $error("byte write lost");
  // ==========================================================
  // alert
  status_set_a: assert property (conv_done[0] && (over_upper_limit[0] || under_lower_limit[0])
    |-> ##[1:2] int_status[0]) else $error("status not set");
  alert_on_a: assert property (!alert_disable_bit && int_status != '0
    |-> ##[0:1] alert_oe == !alert_polarity_bit) else $error("alert not active");
  alert_off_a: assert property ((alert_disable_bit && $stable(alert_polarity_bit)) [*3]
    |-> alert_oe == alert_polarity_bit) else $error("alert not off");
endmodule
`default_nettype wire

/* File: sraa_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sraa_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module sraa_top_tb_top;
  import sraa_pkg::*;
  localparam int NM = `SRAA_NUM_MEAS;
  logic clk, sys_rst, cs_n, sclk, din, dout_o, dout_oe, reg_wr, four_wire_locked;
  logic tw_addr_valid, tw_wdata_valid, tw_rd_req, alert_polarity_bit, alert_disable_bit, alert_o, alert_oe;
  logic [7:0] tw_addr, tw_wdata, tw_rdata, a, d1, d2, d3;
  sraa_ptr_t reg_addr;
  sraa_byte_t reg_wdata, reg_rdata, rxb [5];
  logic [NM-1:0] conv_done, over_upper_limit, under_lower_limit, int_status;
  sraa_byte_t mem [64];
  logic [13:0] exp_q [$];
  logic [13:0] e;
  int err_count, check_count, seed;
  sraa_top uut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
    .dout_oe(dout_oe), .tw_addr_valid(tw_addr_valid), .tw_addr(tw_addr), .tw_wdata_valid(tw_wdata_valid),
    .tw_wdata(tw_wdata), .tw_rd_req(tw_rd_req), .tw_rdata(tw_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done), .over_upper_limit(over_upper_limit),
    .under_lower_limit(under_lower_limit), .alert_polarity_bit(alert_polarity_bit),
    .alert_disable_bit(alert_disable_bit), .int_status(int_status), .alert_o(alert_o), .alert_oe(alert_oe),
    .four_wire_locked(four_wire_locked));
  sraa_spi_master m (.cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe(dout_oe));
  assign reg_rdata = mem[reg_addr];
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // register file model; every write must match the oldest note
  // sampled mid-cycle: reg_wr is combinational from flops that move on the rising edge
  always @(negedge clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      e = exp_q.size() ? exp_q.pop_front() : 14'hx;
      `CHK({reg_addr, reg_wdata}, e)
    end
  end
  // ==========================================================
  // drivers
  task automatic tw_op(input logic av, input logic wv, input logic rv);
    @(negedge clk);
    {tw_addr_valid, tw_wdata_valid, tw_rd_req} = {av, wv, rv};
    @(negedge clk);
    {tw_addr_valid, tw_wdata_valid, tw_rd_req} = 3'h0;
  endtask
  task automatic spi_frame(input sraa_byte_t tx [5], input int n);
    m.open_f();
    for (int i = 0; i < n; i++) m.xbyte(tx[i], rxb[i]);
    m.close_f();
  endtask
  // over and under limits alternate with the measurement picked
  task automatic conv(input int b, input logic bad);
    @(negedge clk);
    conv_done[b] = 1'b1;
    over_upper_limit[b] = bad & ~b[1];
    under_lower_limit[b] = bad & b[1];
    @(negedge clk);
    conv_done = '0;
    repeat (4) @(negedge clk);
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  // ==========================================================
  // scenarios
  initial begin
    seed = 82;
    {sys_rst, tw_addr_valid, tw_wdata_valid, tw_rd_req, alert_polarity_bit, alert_disable_bit} = 6'h20;
    {tw_addr, tw_wdata, conv_done, over_upper_limit, under_lower_limit} = '0;
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    `CHK(alert_oe, 1'b0)
    a = $random(seed);
    d1 = $random(seed);
    d2 = $random(seed);
    d3 = $random(seed);
    tw_addr = a;
    tw_op(1, 0, 0);
    tw_wdata = d1;
    exp_q.push_back({a[5:0], d1});
    tw_op(0, 1, 0);
    tw_wdata = d2;
    exp_q.push_back({a[5:0], d2});
    tw_op(0, 1, 0);
    repeat (2) begin
      tw_op(0, 0, 1);
      `CHK(tw_rdata, d2)
    end
    m.lock_seq();
    repeat (8) @(negedge clk);
    `CHK(four_wire_locked, 1'b1)
    tw_op(0, 1, 0);
    exp_q.push_back({6'h3e, d1});
    exp_q.push_back({6'h3f, d2});
    exp_q.push_back({6'h00, d3});
    spi_frame('{`SRAA_CMD_WRITE, 8'h3e, d1, d2, d3}, 5);
    spi_frame('{`SRAA_CMD_WRITE, 8'h3f, 8'h00, 8'h00, 8'h00}, 2);
    spi_frame('{`SRAA_CMD_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
    `CHK(rxb[1], d2)
    `CHK(rxb[2], d3)
    `CHK(dout_oe, 1'b0)
    spi_frame('{{1'b0, a[6:0]}, 8'h05, d1, d2, 8'h00}, 4);
    `CHK(exp_q.size(), 0)
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      {alert_disable_bit, alert_polarity_bit} = k[1:0];
      conv(2 * k, 1'b1);
      `CHK(int_status, NM'(1) << (2 * k))
      `CHK(alert_oe, k[0] ^ !k[1])
      conv(2 * k, 1'b0);
      `CHK(int_status, NM'(0))
      `CHK(alert_oe, k[0])
    end
    end_sim();
  end
endmodule
bind sraa_top sraa_top_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
  .dout_o(dout_o), .dout_oe(dout_oe), .tw_wdata_valid(tw_wdata_valid), .reg_wr(reg_wr),
  .conv_done(conv_done), .over_upper_limit(over_upper_limit), .under_lower_limit(under_lower_limit),
  .alert_polarity_bit(alert_polarity_bit), .alert_disable_bit(alert_disable_bit),
  .int_status(int_status), .alert_o(alert_o), .alert_oe(alert_oe), .four_wire_locked(four_wire_locked));
`default_nettype wire
